// ===== common/cmc_pkg.sv
// Constants, types and helpers for the cache maintenance block
// Behaviour
// - A write to the L1D flush-all trigger writes back every dirty L1D line and then invalidates all L1D lines.
// - The L2 size field selects one of four capacities, 32KB, 64KB, 128KB or 256KB.
// - The L2 size field is read and write, and a read after a write returns the new size.
// - The L2 mode field selects normal or freeze, and reads back the last value written.
// - Block commands work on whole lines, so every line the range touches even partly is processed.
// - An L2 block writeback takes its base register first and is started by the write of its count.
// - An L2 block invalidate takes its base register first and is started by the write of its count.
// - The L2 block writeback-invalidate writes back the dirty lines of the range and invalidates them.
// - An L2 block writeback-invalidate takes its base first and is started by the write of its count.
// - Status registers show software when the command in progress has finished.
package cmc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_L1D_FLUSH   = 8'h00;
	localparam logic [7:0] OFS_L2_CONFIG   = 8'h04;
	localparam logic [7:0] OFS_WB_BASE     = 8'h08;
	localparam logic [7:0] OFS_WB_COUNT    = 8'h0C;
	localparam logic [7:0] OFS_INV_BASE    = 8'h10;
	localparam logic [7:0] OFS_INV_COUNT   = 8'h14;
	localparam logic [7:0] OFS_WBINV_BASE  = 8'h18;
	localparam logic [7:0] OFS_WBINV_COUNT = 8'h1C;
	localparam logic [7:0] OFS_STATUS      = 8'h20;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CFG_SIZE_LSB  = 0;
	localparam int unsigned CFG_MODE_BIT  = 3;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_OP_LSB   = 1;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Default geometry
	// ----------------------------------------------------------------
	localparam int unsigned DEF_LINE_SHIFT = 7;
	localparam int unsigned DEF_L1D_LINES  = 256;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		L2_SIZE_32K  = 2'h0,
		L2_SIZE_64K  = 2'h1,
		L2_SIZE_128K = 2'h2,
		L2_SIZE_256K = 2'h3
	} cmc_l2_size_t;

	typedef enum logic {
		l2_mode_normal = 1'b0,
		l2_mode_freeze = 1'b1
	} cmc_l2_mode_t;

	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_L1_WB     = 3'h1,
		OP_L1_INV    = 3'h2,
		OP_L2_WB     = 3'h3,
		OP_L2_INV    = 3'h4,
		OP_L2_WBINV  = 3'h5
	} cmc_op_t;

	typedef struct packed {
		cmc_op_t     op;
		logic [31:0] line;
	} cmc_req_t;

	// Lines touched by [base, base+cnt), partial lines included
	function automatic logic [31:0] range_lines(
		input logic [31:0] base,
		input logic [31:0] cnt,
		input int unsigned sh
	);
		logic [32:0] last;
		last = {1'b0, base} + {1'b0, cnt} - 33'h1;
		range_lines = 32'((last >> sh) - {1'b0, base >> sh} + 33'h1);
	endfunction

endpackage

// ===== src/cmc_line_walker.sv
// Steps through a run of cache lines, one request per accepted handshake
`timescale 1ns/1ps
`default_nettype none
module cmc_line_walker
	import cmc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Start of a run
	input  wire logic        start,
	input  wire cmc_op_t     op,
	input  wire logic [31:0] first,
	input  wire logic [31:0] lines,
	// Request to the cache
	output var  cmc_req_t    req_q,
	output var  logic        req_valid_q,
	input  wire logic        req_ready,
	// End of the run
	output var  logic        done_q
);

	logic [31:0] left_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_valid_q <= 1'b0;
			req_q       <= '{op: OP_NONE, line: 32'h0000_0000};
			left_q      <= 32'h0000_0000;
		end else if (start) begin
			req_valid_q <= 1'b1;
			req_q       <= '{op: op, line: first};
			left_q      <= lines;
		end else if (req_valid_q && req_ready) begin
			if (left_q == 32'h0000_0001) begin
				req_valid_q <= 1'b0;
			end else begin
				req_q.line <= req_q.line + 32'h0000_0001;
			end
			left_q <= left_q - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= req_valid_q && req_ready && left_q == 32'h0000_0001;
		end
	end

endmodule
`default_nettype wire

// ===== src/cmc_top.sv
// Cache maintenance command registers and sequencing for L1D and L2
`timescale 1ns/1ps
`default_nettype none
module cmc_top
	import cmc_pkg::*;
#(
	parameter int unsigned LINE_SHIFT = DEF_LINE_SHIFT,
	parameter int unsigned L1D_LINES  = DEF_L1D_LINES
)(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output var  logic [31:0]  reg_rdata_q,
	// Line requests to the cache
	output var  cmc_req_t     maint_req_q,
	output var  logic         maint_valid_q,
	input  wire logic         maint_ready,
	// L2 configuration and busy flag to the cache
	output var  cmc_l2_size_t l2_size_q,
	output var  logic         l2_alloc_en_q,
	output var  logic         busy_q
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_L1_WB,
		ST_L1_INV,
		ST_BLOCK
	} cmc_state_t;

	cmc_state_t   state_q;
	cmc_op_t      cur_op_q;
	cmc_l2_mode_t mode_q;
	logic [31:0]  wb_base_q;
	logic [31:0]  inv_base_q;
	logic [31:0]  wbinv_base_q;
	logic [31:0]  wb_count_q;
	logic [31:0]  inv_count_q;
	logic [31:0]  wbinv_count_q;

	logic         wr_flush;
	logic         wr_wb_cnt;
	logic         wr_inv_cnt;
	logic         wr_wbinv_cnt;
	logic         walk_start;
	cmc_op_t      walk_op;
	logic [31:0]  walk_first;
	logic [31:0]  walk_lines;
	logic [31:0]  sel_base;
	logic         walk_done;
	logic         l1_wb_done;
	logic         idle;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands are taken only when idle; a zero count starts nothing
	assign idle         = state_q == ST_IDLE;
	assign wr_flush     = reg_wr && idle && reg_addr == OFS_L1D_FLUSH;
	assign wr_wb_cnt    = reg_wr && idle && reg_addr == OFS_WB_COUNT
		&& reg_wdata != 32'h0000_0000;
	assign wr_inv_cnt   = reg_wr && idle && reg_addr == OFS_INV_COUNT
		&& reg_wdata != 32'h0000_0000;
	assign wr_wbinv_cnt = reg_wr && idle && reg_addr == OFS_WBINV_COUNT
		&& reg_wdata != 32'h0000_0000;
	assign l1_wb_done   = walk_done && state_q == ST_L1_WB;

	always_comb begin
		walk_start = 1'b0;
		walk_op    = OP_NONE;
		sel_base   = 32'h0000_0000;
		walk_first = 32'h0000_0000;
		walk_lines = 32'h0000_0000;
		if (wr_flush) begin
			walk_start = 1'b1;
			walk_op    = OP_L1_WB;
			walk_lines = 32'(L1D_LINES);
		end else if (l1_wb_done) begin
			walk_start = 1'b1;
			walk_op    = OP_L1_INV;
			walk_lines = 32'(L1D_LINES);
		end else if (wr_wb_cnt || wr_inv_cnt || wr_wbinv_cnt) begin
			walk_start = 1'b1;
			if (wr_wb_cnt) begin
				walk_op  = OP_L2_WB;
				sel_base = wb_base_q;
			end else if (wr_inv_cnt) begin
				walk_op  = OP_L2_INV;
				sel_base = inv_base_q;
			end else begin
				walk_op  = OP_L2_WBINV;
				sel_base = wbinv_base_q;
			end
			walk_first = sel_base >> LINE_SHIFT;
			walk_lines = range_lines(sel_base, reg_wdata, LINE_SHIFT);
		end
	end

	// ----------------------------------------------------------------
	// Line walker
	// ----------------------------------------------------------------
	cmc_line_walker u_walker (
		.clk         (clk),
		.rst         (rst),
		.start       (walk_start),
		.op          (walk_op),
		.first       (walk_first),
		.lines       (walk_lines),
		.req_q       (maint_req_q),
		.req_valid_q (maint_valid_q),
		.req_ready   (maint_ready),
		.done_q      (walk_done)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q  <= ST_IDLE;
			cur_op_q <= OP_NONE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (wr_flush) begin
						state_q <= ST_L1_WB;
					end else if (walk_start) begin
						state_q <= ST_BLOCK;
					end
					if (walk_start) begin
						cur_op_q <= walk_op;
					end
				end
				ST_L1_WB: begin
					// Invalidation waits for the last writeback
					if (walk_done) begin
						state_q  <= ST_L1_INV;
						cur_op_q <= OP_L1_INV;
					end
				end
				ST_L1_INV, ST_BLOCK: begin
					if (walk_done) begin
						state_q  <= ST_IDLE;
						cur_op_q <= OP_NONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= walk_start || (!idle && !(walk_done
				&& state_q != ST_L1_WB));
		end
	end

	// ----------------------------------------------------------------
	// L2 configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			l2_size_q <= L2_SIZE_32K;
			mode_q    <= l2_mode_normal;
		end else if (reg_wr && reg_addr == OFS_L2_CONFIG) begin
			l2_size_q <= cmc_l2_size_t'(reg_wdata[CFG_SIZE_LSB +: 2]);
			mode_q    <= cmc_l2_mode_t'(reg_wdata[CFG_MODE_BIT]);
		end
	end

	// Freeze keeps hits but blocks allocation on misses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			l2_alloc_en_q <= 1'b1;
		end else if (reg_wr && reg_addr == OFS_L2_CONFIG) begin
			l2_alloc_en_q <= reg_wdata[CFG_MODE_BIT] == l2_mode_normal;
		end
	end

	// ----------------------------------------------------------------
	// Base and count registers
	// ----------------------------------------------------------------
	// Bases may be rewritten at any time; a running walk holds its copy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_base_q    <= RST_WORD;
			inv_base_q   <= RST_WORD;
			wbinv_base_q <= RST_WORD;
		end else if (reg_wr) begin
			if (reg_addr == OFS_WB_BASE) begin
				wb_base_q <= reg_wdata;
			end
			if (reg_addr == OFS_INV_BASE) begin
				inv_base_q <= reg_wdata;
			end
			if (reg_addr == OFS_WBINV_BASE) begin
				wbinv_base_q <= reg_wdata;
			end
		end
	end

	// Counts drop to zero when their command finishes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_count_q    <= RST_WORD;
			inv_count_q   <= RST_WORD;
			wbinv_count_q <= RST_WORD;
		end else begin
			if (wr_wb_cnt) begin
				wb_count_q <= reg_wdata;
			end else if (walk_done && cur_op_q == OP_L2_WB) begin
				wb_count_q <= 32'h0000_0000;
			end
			if (wr_inv_cnt) begin
				inv_count_q <= reg_wdata;
			end else if (walk_done && cur_op_q == OP_L2_INV) begin
				inv_count_q <= 32'h0000_0000;
			end
			if (wr_wbinv_cnt) begin
				wbinv_count_q <= reg_wdata;
			end else if (walk_done && cur_op_q == OP_L2_WBINV) begin
				wbinv_count_q <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= RST_WORD;
		end else if (reg_rd) begin
			reg_rdata_q <= 32'h0000_0000;
			unique case (reg_addr)
				OFS_L1D_FLUSH: begin
					reg_rdata_q[STAT_BUSY_BIT] <= state_q == ST_L1_WB
						|| state_q == ST_L1_INV;
				end
				OFS_L2_CONFIG: begin
					reg_rdata_q[CFG_SIZE_LSB +: 2] <= l2_size_q;
					reg_rdata_q[CFG_MODE_BIT]      <= mode_q;
				end
				OFS_WB_BASE:     reg_rdata_q <= wb_base_q;
				OFS_WB_COUNT:    reg_rdata_q <= wb_count_q;
				OFS_INV_BASE:    reg_rdata_q <= inv_base_q;
				OFS_INV_COUNT:   reg_rdata_q <= inv_count_q;
				OFS_WBINV_BASE:  reg_rdata_q <= wbinv_base_q;
				OFS_WBINV_COUNT: reg_rdata_q <= wbinv_count_q;
				OFS_STATUS: begin
					reg_rdata_q[STAT_BUSY_BIT] <= !idle;
					reg_rdata_q[STAT_OP_LSB +: 3] <= cur_op_q;
				end
				default: reg_rdata_q <= 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== tb/cmc_top_sva.sv
// Port checker for the cache maintenance block
`timescale 1ns/1ps
`default_nettype none
module cmc_top_sva
	import cmc_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [31:0]  reg_rdata_q,
	// Cache side
	input  wire cmc_req_t     maint_req_q,
	input  wire logic         maint_valid_q,
	input  wire logic         maint_ready,
	input  wire cmc_l2_size_t l2_size_q,
	input  wire logic         l2_alloc_en_q,
	input  wire logic         busy_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Count writes only start when idle and non-zero
	wire logic go = reg_wr && !busy_q && reg_wdata != 32'h0;
	// --------------------------------------------------
	// Assertions
	// --------------------------------------------------
	req_hold_a: assert property (maint_valid_q && !maint_ready
		|=> maint_valid_q && $stable(maint_req_q)) else $error("req dropped");
	valid_busy_a: assert property (maint_valid_q |-> busy_q)
		else $error("valid without busy");
	wb_start_a: assert property (go && reg_addr == OFS_WB_COUNT
		|=> maint_valid_q && maint_req_q.op == OP_L2_WB) else $error("wb");
	inv_start_a: assert property (go && reg_addr == OFS_INV_COUNT
		|=> maint_valid_q && maint_req_q.op == OP_L2_INV) else $error("inv");
	wbinv_start_a: assert property (go && reg_addr == OFS_WBINV_COUNT
		|=> maint_valid_q && maint_req_q.op == OP_L2_WBINV) else $error("wbi");
	flush_start_a: assert property (reg_wr && !busy_q
		&& reg_addr == OFS_L1D_FLUSH |=> maint_valid_q
		&& maint_req_q.op == OP_L1_WB && maint_req_q.line == 32'h0)
		else $error("flush start");
	line_step_a: assert property (maint_valid_q && maint_ready ##1
		(maint_valid_q && maint_req_q.op == $past(maint_req_q.op))
		|-> maint_req_q.line == $past(maint_req_q.line) + 32'h1)
		else $error("line step");
	size_write_a: assert property (reg_wr && reg_addr == OFS_L2_CONFIG
		|=> l2_size_q == $past(reg_wdata[1:0])) else $error("size");
	mode_write_a: assert property (reg_wr && reg_addr == OFS_L2_CONFIG
		|=> l2_alloc_en_q == !$past(reg_wdata[3])) else $error("mode");
	config_read_a: assert property (reg_rd && reg_addr == OFS_L2_CONFIG
		|=> reg_rdata_q[1:0] == l2_size_q && reg_rdata_q[3] == !l2_alloc_en_q)
		else $error("config read");
	cover property (maint_valid_q && !maint_ready);
	cover property (maint_valid_q && maint_req_q.op == OP_L1_INV);
	cover property (!l2_alloc_en_q);
endmodule
`default_nettype wire

// ===== tb/cmc_cache_model.sv
// Cache-side model accepting maintenance requests, prompt or stalling
`timescale 1ns/1ps
`default_nettype none
module cmc_cache_model
	import cmc_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst,
	// Request from the block
	input  wire cmc_req_t maint_req_q,
	input  wire logic     maint_valid_q,
	output var  logic     maint_ready,
	// Stall control
	input  wire logic     slow
);
	cmc_req_t got[$];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			maint_ready <= 1'b0;
		end else begin
			// Rare ready so a block command outlives two reads
			maint_ready <= slow ? ($urandom % 8 == 0) : 1'b1;
			if (maint_valid_q && maint_ready)
				got.push_back(maint_req_q);
		end
	end
endmodule
`default_nettype wire

// ===== tb/cmc_top_tb.sv
// Self-checking bench for the cache maintenance block
`timescale 1ns/1ps
`default_nettype none
module cmc_top_tb
	import cmc_pkg::*;
;
	localparam int unsigned NL = 4;
	logic         clk       = 1'b0;
	logic         rst       = 1'b1;
	logic [7:0]   reg_addr  = 8'h00;
	logic [31:0]  reg_wdata = 32'h0;
	logic         reg_wr    = 1'b0;
	logic         reg_rd    = 1'b0;
	logic         slow      = 1'b1;
	logic [31:0]  reg_rdata_q, d, base, cnt;
	cmc_req_t     maint_req_q;
	logic         maint_valid_q, maint_ready, l2_alloc_en_q, busy_q;
	cmc_l2_size_t l2_size_q;
	cmc_op_t      op;
	cmc_req_t     exp_q[$];
	int           n_fail    = 0;
	int           cmp_count = 0;
	always #4 clk = ~clk;
	cmc_top #(.L1D_LINES(NL)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .maint_req_q(maint_req_q),
		.maint_valid_q(maint_valid_q), .maint_ready(maint_ready),
		.l2_size_q(l2_size_q), .l2_alloc_en_q(l2_alloc_en_q), .busy_q(busy_q));
	cmc_cache_model model (.clk(clk), .rst(rst), .maint_req_q(maint_req_q),
		.maint_valid_q(maint_valid_q), .maint_ready(maint_ready), .slow(slow));
	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	task automatic idle();
		int i;
		i = 0;
		#1;
		while (busy_q !== 1'b0 && i < 5000) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i == 5000) begin
			n_fail++;
			$display("Error at %0t: command never finished", $time);
		end
	endtask
	task automatic drain();
		chk(35'(model.got.size()), 35'(exp_q.size()));
		foreach (exp_q[i])
			if (i < model.got.size())
				chk(model.got[i], exp_q[i]);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#400000;
		n_fail++;
		test_done();
	end
	initial begin
		void'($urandom(32'h8ea7deab));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(35'(l2_size_q), 35'(L2_SIZE_32K));
		chk(35'(l2_alloc_en_q), 35'h1);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_L2_CONFIG, {28'h0, i[2], 1'b0, i[1:0]});
			#1 chk(35'(l2_size_q), 35'(i[1:0]));
			chk(35'(l2_alloc_en_q), 35'(!i[2]));
			rd(OFS_L2_CONFIG);
			chk(35'(d), 35'({i[2], 1'b0, i[1:0]}));
		end
		// Unaligned ranges so edge lines are partial; last pass aligned
		for (int k = 0; k < 4; k++) begin
			base = $urandom;
			cnt = 257 + $urandom % 300;
			if (k == 3) begin
				base = (base >> DEF_LINE_SHIFT) << DEF_LINE_SHIFT;
				cnt = 32'((3 + $urandom % 3) << DEF_LINE_SHIFT);
			end
			op = cmc_op_t'(3'(3 + k % 3));
			exp_q.delete();
			model.got.delete();
			for (longint a = base >> DEF_LINE_SHIFT;
				a <= (longint'(base) + cnt - 1) >> DEF_LINE_SHIFT; a++)
				exp_q.push_back({op, a[31:0]});
			wr(8'(8 + 8 * (k % 3)), base);
			wr(8'(12 + 8 * (k % 3)), cnt);
			rd(8'(12 + 8 * (k % 3)));
			chk(35'(d != 32'h0), 35'h1);
			rd(OFS_STATUS);
			chk(35'(d[3:0]), 35'({op, 1'b1}));
			idle();
			rd(8'(12 + 8 * (k % 3)));
			chk(35'(d), 35'h0);
			drain();
		end
		slow <= 1'b0;
		exp_q.delete();
		model.got.delete();
		for (int p = 1; p < 3; p++)
			for (int s = 0; s < NL; s++)
				exp_q.push_back({3'(p), 32'(s)});
		wr(OFS_L1D_FLUSH, $urandom);
		rd(OFS_L1D_FLUSH);
		chk(35'(d[0]), 35'h1);
		idle();
		rd(OFS_L1D_FLUSH);
		chk(35'(d), 35'h0);
		drain();
		test_done();
	end
endmodule
bind cmc_top cmc_top_sva u_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .maint_req_q(maint_req_q),
	.maint_valid_q(maint_valid_q), .maint_ready(maint_ready),
	.l2_size_q(l2_size_q), .l2_alloc_en_q(l2_alloc_en_q), .busy_q(busy_q));
`default_nettype wire
